// ===== core/sfs_pkg.sv
/*
 * sfs_pkg: shared constants for the synchronous flow-through sram port.
 * assumes: imported whole by the fifo and port design files; the buffer interface does not import it.
 */
package sfs_pkg;
    // ************************************************************
    // geometry
    // ************************************************************
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int WORD_W = LANES * LANE_W;
    localparam int ADDR_W_DEF = 18;
    localparam int SEED_W = 2;
    localparam int SEED_POS = 0;
    localparam int BUF_DEPTH_DEF = 16;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [SEED_W-1:0] CNT_RST = 2'h0;
    localparam logic [SEED_W-1:0] CNT_STEP = 2'h1;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [WORD_W-1:0] WORD_RST = 36'h0;

    typedef enum logic [1:0] {
        SFS_IDLE = 2'b00,
        SFS_READ = 2'b01,
        SFS_WRITE = 2'b10
    } sfs_phase_t;
endpackage : sfs_pkg

// ===== core/sfs_buf_if.sv
/*
 * sfs_buf_if: valid/ready stream between the port and its write buffer.
 * assumes: one clock; payload width chosen by the instantiating module.
 */
`timescale 1ns/1ns
interface sfs_buf_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sfs_buf_if

// ===== core/sfs_fifo.sv
/*
 * sfs_fifo: synchronous fifo holding array writes on their way in.
 * assumes: single clock, async active-low reset, clock enable freezes all.
 */
`timescale 1ns/1ns
module sfs_fifo import sfs_pkg::*; #(
    parameter int W = 8,
    parameter int DEPTH = BUF_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    sfs_buf_if.snk push,
    sfs_buf_if.src pop
);
    localparam int PW = $clog2(DEPTH);

    // ************************************************************
    // storage and pointers
    // ************************************************************
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic full;
    wire do_push = en && push.valid && !full;
    wire do_pop = en && pop.valid && pop.ready;
    wire [PW:0] next_count = count + (PW+1)'(do_push) - (PW+1)'(do_pop);

    assign push.ready = !full;
    assign pop.valid = (count != '0);
    assign pop.data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push.data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            full <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr + PW'(do_push);
            rd_ptr <= rd_ptr + PW'(do_pop);
            count <= next_count;
            full <= (next_count == (PW+1)'(DEPTH));
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_b)
        count <= (PW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : sfs_fifo

// ===== core/sfs_port.sv
/*
 * sfs_port: synchronous flow-through sram with zero turnaround, 4x9-bit lanes.
 * assumes: inputs synchronous to REF_CLK; the two-way data bus is resolved
 * outside from DATA_OUT and DATA_OE.
 */
// How it works
// - address captured when load, clock enabled, sleep low and all three selects true
// - two low address bits seed the burst counter on each load
// - every nine-bit lane has its own active-low write enable
// - lane enables ignored when the edge samples read
// - enabled lanes stored from the bus one cycle after the write command
// - enable 0..3 governs lane 0..3 respectively
// - clock gate high freezes everything as if the edge never happened
// - direction sampled at load holds for the whole burst
// - data moves exactly one cycle after the accepted command
// - all on rising edge except output enable; sleep and burst order are sampled at the edge too
// - any select false during load starts a deselect cycle
// - bus floats one cycle after a deselect
// - read data drives only while output enable is low
// - load with chip selected and sleep low refreshes address and control registers
// - advance with sleep low steps the counter of a burst in progress
// - address and direction ignored while advancing
// - burst order high selects interleaved, low selects linear
// - sleep high enters standby; normal use needs it low
// - a load and each following advance yield one transfer each; the two-bit counter wraps after four
// - pending transfer still completes after deselect or burst stop
// - bus released one cycle after a write starts
`timescale 1ns/1ns
module sfs_port import sfs_pkg::*; #(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int BUF_DEPTH = BUF_DEPTH_DEF
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic CLOCK_GATE_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic ADVANCE_OR_LOAD,
    input wire logic READ_WRITE_SEL,
    input wire logic [LANES-1:0] LANE_WRITE_N,
    input wire logic CHIP_SEL_FIRST_N,
    input wire logic CHIP_SEL_SECOND,
    input wire logic CHIP_SEL_THIRD_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SLEEP_REQUEST,
    input wire logic BURST_ORDER,
    input wire logic [WORD_W-1:0] DATA_IN,
    output logic [WORD_W-1:0] DATA_OUT,
    output logic [WORD_W-1:0] DATA_OE,
    output logic WR_BUF_READY,
    output logic STANDBY
);
    localparam int BUF_W = ADDR_W + LANES + WORD_W;

    // ************************************************************
    // lane merge helper
    // ************************************************************
    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old_w,
        input logic [WORD_W-1:0] new_w, input logic [LANES-1:0] sel);
        logic [WORD_W-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (sel[i]) begin
                res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction : merge

    // ************************************************************
    // state
    // ************************************************************
    logic [WORD_W-1:0] array [2**ADDR_W];
    logic burst_active;
    logic burst_write;
    logic [ADDR_W-1:0] burst_base;
    logic [SEED_W-1:0] burst_cnt;
    sfs_phase_t phase;
    logic [ADDR_W-1:0] phase_addr;
    logic [LANES-1:0] phase_lanes;
    logic drive;

    sfs_buf_if #(.W(BUF_W)) push_if ();
    sfs_buf_if #(.W(BUF_W)) pop_if ();

    // ************************************************************
    // command decode
    // ************************************************************
    wire en = !CLOCK_GATE_N;
    wire selected = !CHIP_SEL_FIRST_N && CHIP_SEL_SECOND && !CHIP_SEL_THIRD_N;
    wire is_load = en && !ADVANCE_OR_LOAD;
    wire do_load = is_load && selected && !SLEEP_REQUEST;
    wire do_desel = is_load && !do_load;
    wire do_adv = en && ADVANCE_OR_LOAD && burst_active && !SLEEP_REQUEST;
    wire [SEED_W-1:0] seed = burst_base[SEED_POS +: SEED_W];
    wire [SEED_W-1:0] next_cnt = burst_cnt + CNT_STEP;
    wire [SEED_W-1:0] order_lo = BURST_ORDER ? (seed ^ next_cnt)
                                             : (seed + next_cnt);
    wire [ADDR_W-1:0] adv_addr = {burst_base[ADDR_W-1:SEED_W], order_lo};
    wire [ADDR_W-1:0] issue_addr = do_load ? ADDR : adv_addr;
    wire issue_write = do_load ? !READ_WRITE_SEL : burst_write;
    wire want_issue = do_load || do_adv;
    wire issue_ok = want_issue && (!issue_write || push_if.ready);
    wire [LANES-1:0] issue_lanes = issue_write ? ~LANE_WRITE_N : LANES_NONE;
    wire wr_phase = en && (phase == SFS_WRITE);

    // ************************************************************
    // write buffer: data phase pushes, array pops
    // ************************************************************
    assign push_if.valid = wr_phase;
    assign push_if.data = {phase_addr, phase_lanes, DATA_IN};
    assign pop_if.ready = en;
    wire pop_now = en && pop_if.valid && pop_if.ready;
    wire [ADDR_W-1:0] pop_addr = pop_if.data[BUF_W-1 -: ADDR_W];
    wire [LANES-1:0] pop_lanes = pop_if.data[WORD_W +: LANES];
    wire [WORD_W-1:0] pop_word = pop_if.data[WORD_W-1:0];

    sfs_fifo #(.W(BUF_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .en(en),
        .push(push_if),
        .pop(pop_if)
    );

    // ************************************************************
    // read path with forwarding from pending writes
    // ************************************************************
    wire [WORD_W-1:0] raw_rd = array[issue_addr];
    wire fwd_pop = pop_now && (pop_addr == issue_addr);
    wire fwd_bus = wr_phase && (phase_addr == issue_addr);
    wire [WORD_W-1:0] rd_pop = merge(raw_rd, pop_word, fwd_pop ? pop_lanes : LANES_NONE);
    wire [WORD_W-1:0] rd_word = merge(rd_pop, DATA_IN, fwd_bus ? phase_lanes : LANES_NONE);
    wire next_drive = issue_ok && !issue_write;
    wire [WORD_W-1:0] next_out = next_drive ? rd_word : DATA_OUT;

    always_ff @(posedge REF_CLK) begin
        if (pop_now) begin
            array[pop_addr] <= merge(array[pop_addr], pop_word, pop_lanes);
        end
    end

    // ************************************************************
    // burst control
    // ************************************************************
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            burst_active <= 1'b0;
            burst_write <= 1'b0;
            burst_base <= '0;
            burst_cnt <= CNT_RST;
        end else if (do_load) begin
            burst_active <= 1'b1;
            burst_write <= !READ_WRITE_SEL;
            burst_base <= ADDR;
            burst_cnt <= CNT_RST;
        end else if (do_desel) begin
            burst_active <= 1'b0;
        end else if (do_adv) begin
            burst_cnt <= next_cnt;
        end
    end

    // ************************************************************
    // data phase and outputs
    // ************************************************************
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            phase <= SFS_IDLE;
            phase_addr <= '0;
            phase_lanes <= LANES_NONE;
            drive <= 1'b0;
            DATA_OUT <= WORD_RST;
            WR_BUF_READY <= 1'b1;
            STANDBY <= 1'b0;
        end else if (en) begin
            phase <= !issue_ok ? SFS_IDLE : (issue_write ? SFS_WRITE : SFS_READ);
            phase_addr <= issue_addr;
            phase_lanes <= issue_lanes;
            drive <= next_drive;
            DATA_OUT <= next_out;
            WR_BUF_READY <= push_if.ready;
            STANDBY <= SLEEP_REQUEST;
        end
    end

    assign DATA_OE = {WORD_W{drive && !OUTPUT_ENABLE_N}};

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    a_oe_follows_pin: assert property (OUTPUT_ENABLE_N |-> DATA_OE == '0)
        else $error("bus driven while output enable high");
    a_desel_float: assert property (do_desel |=> DATA_OE == '0)
        else $error("bus not floated after deselect");
    a_write_float: assert property (want_issue && issue_write |=> DATA_OE == '0)
        else $error("bus not released after write command");
    a_read_drives: assert property (next_drive && !OUTPUT_ENABLE_N
        |=> DATA_OE != '0 || OUTPUT_ENABLE_N)
        else $error("read data not driven next cycle");
    a_freeze_all: assert property (!en |=> $stable(burst_cnt) && $stable(DATA_OUT)
        && $stable(burst_base))
        else $error("state moved with clock gate high");
    a_load_seed: assert property (do_load |=> burst_cnt == CNT_RST
        && burst_base == $past(ADDR))
        else $error("load did not capture address");
    a_dir_held: assert property (do_adv |=> $stable(burst_write))
        else $error("direction changed during burst");
    a_adv_step: assert property (do_adv |=> burst_cnt == $past(burst_cnt) + CNT_STEP)
        else $error("burst counter did not step");
    a_write_one_later: assert property (en && issue_ok && issue_write
        |=> phase == SFS_WRITE)
        else $error("write data phase not one cycle later");
    a_read_no_lanes: assert property (issue_ok && !issue_write
        |=> phase_lanes == LANES_NONE)
        else $error("lane enables honoured on read");

    c_load_read: cover property (do_load && READ_WRITE_SEL ##1 do_adv [*3]);
    c_load_write: cover property (do_load && !READ_WRITE_SEL ##1 do_adv);
    c_desel: cover property (do_load ##1 do_desel);
    c_freeze: cover property (burst_active && !en ##1 en);
endmodule : sfs_port

// ===== verif/sfs_host_model.sv
/*
 * sfs_host_model: host side of the shared data bus, resolving it per bit.
 * assumes: bench says when the host drives; undriven bits toggle each clock.
 */
`timescale 1ns/1ns
module sfs_host_model import sfs_pkg::*; (
    input wire logic clk,
    input wire logic host_drive,
    input wire logic [WORD_W-1:0] host_word,
    input wire logic [WORD_W-1:0] dev_oe,
    input wire logic [WORD_W-1:0] dev_word,
    output logic [WORD_W-1:0] bus
);
    // ********************
    // bus resolution
    // ********************
    logic [WORD_W-1:0] float_pat = 36'h5a5a5a5a5;

    always @(posedge clk) begin
        float_pat <= ~float_pat;
    end

    always_comb begin
        for (int i = 0; i < WORD_W; i++) begin
            bus[i] = dev_oe[i] ? dev_word[i] : (host_drive ? host_word[i] : float_pat[i]);
        end
    end
endmodule : sfs_host_model

// ===== verif/tb_top.sv
/*
 * tb_top: random self-checking bench for sfs_port against a reference memory.
 * assumes: sfs_pkg compiled first; the host model resolves the shared bus.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_top import sfs_pkg::*; ;
    // ********************
    // signals
    // ********************
    localparam int AW = 6;
    logic clk = 1'h0, rst_b = 1'h0, gate_n = 1'h0, adv = 1'h0, rw = 1'h1, cs1_n = 1'h1;
    logic cs2 = 1'h0, cs3_n = 1'h1, oe_n = 1'h0, sleep = 1'h0, order = 1'h0, hdrv = 1'h0;
    logic oe_v = 1'h0, slp_v = 1'h0, ord_v = 1'h0, act = 1'h0, dir = 1'h0, pend = 1'h0;
    logic stby, bufrdy;
    logic [AW-1:0] addr = 6'h0, base, pend_a;
    logic [LANES-1:0] lanes = 4'h0, pend_ln;
    logic [1:0] n;
    logic [WORD_W-1:0] din, dout, doe, hword = 36'h0, pend_d, exp_w;
    logic [WORD_W-1:0] mem [2**AW];
    logic [WORD_W-1:0] expq [$];
    int n_fail = 0, n_tests = 0, cycles = 0;

    initial begin
        forever #10 clk = ~clk;
    end

    sfs_port #(.ADDR_W(AW), .BUF_DEPTH(BUF_DEPTH_DEF)) dut (.REF_CLK(clk), .RST_B(rst_b),
        .CLOCK_GATE_N(gate_n), .ADDR(addr), .ADVANCE_OR_LOAD(adv), .READ_WRITE_SEL(rw),
        .LANE_WRITE_N(lanes), .CHIP_SEL_FIRST_N(cs1_n), .CHIP_SEL_SECOND(cs2),
        .CHIP_SEL_THIRD_N(cs3_n), .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(sleep),
        .BURST_ORDER(order), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
        .WR_BUF_READY(bufrdy), .STANDBY(stby));

    sfs_host_model host (.clk(clk), .host_drive(hdrv), .host_word(hword), .dev_oe(doe),
        .dev_word(dout), .bus(din));

    // ********************
    // tasks
    // ********************
    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic step(input logic g, input logic a_l, input logic r, input logic [AW-1:0] a,
            input logic [LANES-1:0] ln, input logic [1:0] ds);
        logic [AW-1:0] ad;
        @(negedge clk);
        gate_n = g;
        adv = a_l;
        rw = r;
        addr = a;
        lanes = ln;
        cs1_n = (ds == 2'h1);
        cs2 = (ds != 2'h2);
        cs3_n = (ds == 2'h3);
        oe_n = oe_v;
        sleep = slp_v;
        order = ord_v;
        hdrv = pend;
        hword = pend_d;
        @(posedge clk);
        #1;
        if (g) return;
        `CHK(stby, slp_v)
        `CHK(bufrdy, 1'h1)
        for (int i = 0; i < LANES; i++) begin
            if (pend && !pend_ln[i]) begin
                mem[pend_a][i*LANE_W +: LANE_W] = pend_d[i*LANE_W +: LANE_W];
            end
        end
        pend = 1'h0;
        if (!a_l) begin
            act = (ds == 2'h0) && !slp_v;
            base = a;
            dir = r;
            n = 2'h0;
        end else if (act) begin
            n = n + 2'h1;
        end
        if (!act) return;
        ad = {base[AW-1:2], ord_v ? base[1:0] ^ n : base[1:0] + n};
        if (dir) begin
            expq.push_back(mem[ad]);
        end else begin
            pend = 1'h1;
            pend_a = ad;
            pend_ln = ln;
            pend_d = WORD_W'({$urandom, $urandom});
        end
    endtask : step

    // ********************
    // output watcher and timeout
    // ********************
    always @(posedge clk) begin
        if (rst_b && gate_n === 1'h0) begin
            if (expq.size() != 0) begin
                exp_w = expq.pop_front();
                `CHK(dout, exp_w)
                `CHK(doe, {WORD_W{!oe_n}})
            end else begin
                `CHK(doe, {WORD_W{1'h0}})
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ********************
    // main sequence
    // ********************
    initial begin
        void'($urandom(47));
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_b = 1'h1;
        `CHK(dout, WORD_RST)
        for (int k = 0; k < 2**AW; k++) begin
            step(1'h0, k % 4 != 0, 1'h0, AW'(k), LANES_NONE, 2'h0);
        end
        for (int p = 0; p < 2; p++) begin
            step(1'h0, 1'h0, 1'h1, 6'h0, 4'hf, 2'h1);
            step(1'h0, 1'h0, 1'h1, 6'h0, 4'hf, 2'h2);
            ord_v = p[0];
            for (int k = 0; k < 300; k++) begin
                if ($urandom % 16 == 0) slp_v = ~slp_v;
                oe_v = ($urandom % 8 == 0);
                step($urandom % 8 == 0, !slp_v && $urandom % 3 != 0, 1'($urandom),
                    AW'($urandom), LANES'($urandom),
                    ($urandom % 5 == 0) ? 2'($urandom % 3 + 1) : 2'h0);
            end
        end
        step(1'h0, 1'h0, 1'h1, 6'h0, 4'hf, 2'h3);
        step(1'h0, 1'h0, 1'h1, 6'h0, 4'hf, 2'h3);
        `CHK(expq.size(), 0)
        tally_and_finish();
    end
endmodule : tb_top
